/* rtl/slrm_pkg.sv */
// Constants and types shared by the sleep and receive mode controller
`default_nettype none
package slrm_pkg;
  // Timing: one ms tick drives every long timer
  localparam int SLRM_CLK_NS = 20;
  localparam int SLRM_MS_NS = 1000000;
  localparam int SLRM_TICK_CYC = SLRM_MS_NS / SLRM_CLK_NS;
  localparam int SLRM_PWAKE_MS = 85;
  localparam int SLRM_LISTEN_MS = 100;
  localparam int SLRM_CYC_BASE_MS = 500;
  localparam int SLRM_PKT_MAX = 64;
  localparam int SLRM_CRC_BYTES = 2;
  // Sleep mode selection codes
  localparam logic [2:0] SLRM_SM_OFF = 3'h0;
  localparam logic [2:0] SLRM_SM_PIN = 3'h1;
  localparam logic [2:0] SLRM_SM_SER = 3'h2;
  localparam logic [2:0] SLRM_SM_CYC_MIN = 3'h3;
  // Register indices
  localparam logic [3:0] SLRM_REG_SM = 4'h0;
  localparam logic [3:0] SLRM_REG_ST = 4'h1;
  localparam logic [3:0] SLRM_REG_LH = 4'h2;
  localparam logic [3:0] SLRM_REG_HT = 4'h3;
  localparam logic [3:0] SLRM_REG_STAT = 4'h4;
  localparam logic [3:0] SLRM_REG_DROP = 4'h5;
  // Reset values
  localparam logic [2:0] SLRM_SM_RST = 3'h0;
  localparam logic [15:0] SLRM_ST_RST = 16'h0064;
  localparam logic [15:0] SLRM_LH_RST = 16'h0000;
  localparam logic [15:0] SLRM_HT_RST = 16'h03e8;
  // Status field positions
  localparam int SLRM_STAT_MODE = 0;
  localparam int SLRM_STAT_PEND = 3;
  localparam int SLRM_STAT_CTS_N = 4;
  localparam int SLRM_STAT_ACT = 5;
  localparam int SLRM_STAT_LHDR = 6;
  localparam int SLRM_STAT_FWD = 7;
  // CRC
  localparam logic [15:0] SLRM_CRC_POLY = 16'h1021;
  localparam logic [15:0] SLRM_CRC_INIT = 16'h0000;

  typedef enum logic [2:0] {
    SLRM_IDLE = 3'b000,
    SLRM_RX = 3'b001,
    SLRM_TX = 3'b011,
    SLRM_SLEEP = 3'b010,
    SLRM_LISTEN = 3'b110,
    SLRM_PWAKE = 3'b111
  } slrm_mode_t;
endpackage
`default_nettype wire

/* rtl/slrm_tick.sv */
// Millisecond tick generator
`default_nettype none
module slrm_tick import slrm_pkg::*; #(
  parameter int TICK_CYCLES = SLRM_TICK_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  output logic tick
);
  localparam int CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } slrm_tick_t;
  slrm_tick_t s_ff;
  slrm_tick_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (s_ff.cnt == CW'(TICK_CYCLES - 1)) begin
      nxt_s.cnt = '0;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.cnt = s_ff.cnt + CW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick = s_ff.tick;
endmodule
`default_nettype wire

/* rtl/slrm_crc16.sv */
// Running 16-bit packet check over received bytes
`default_nettype none
module slrm_crc16 import slrm_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [15:0] crc
);
  typedef struct packed {
    logic [15:0] crc;
  } slrm_crc_t;
  slrm_crc_t s_ff;
  slrm_crc_t nxt_s;

  // Trailing check bytes sent high first leave a zero residue
  function automatic logic [15:0] upd(input logic [15:0] c,
                                      input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ SLRM_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  always_comb begin
    nxt_s = s_ff;
    if (clr) begin
      nxt_s.crc = en ? upd(SLRM_CRC_INIT, data) : SLRM_CRC_INIT;
    end else if (en) begin
      nxt_s.crc = upd(s_ff.crc, data);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign crc = s_ff.crc;
endmodule
`default_nettype wire

/* rtl/slrm_ctrl.sv */
// Sleep and receive mode controller of a half-duplex radio module
// Function
// - Idle plus air data enters receive
// - Bad check drops packet, good forwards
// - Receive ends on error or silence
// - Serial input during receive sent afterwards
// - Asleep means no transmit, no receive
// - Sleep disabled after reset defaults
// - Auto sleep after configured inactivity only
// - Pin high sleeps, low runs
// - Pin release takes 85 ms to idle
// - Sleep pin ignored unless pin mode
// - Pin sleep: send permit high, activity low
// - Serial sleep: timeout, any character wakes
// - Cyclic sleep period 0.5 to 8 s
// - Cyclic wake searches, then sleeps, receives or transmits
// - Each cyclic wake searches 100 ms
// - Cyclic: permit high asleep, low awake
// - Cyclic: activity low asleep, high awake
// - Long header off by default, timed
// - Long header only after idle period
// - Packets carry trailing 16-bit check
// - Send permit low invites host data
//
// Strobed register access and the register offsets were decided locally.
`default_nettype none
module slrm_ctrl import slrm_pkg::*; #(
  parameter int TICK_CYCLES = SLRM_TICK_CYC,
  parameter int PKT_MAX = SLRM_PKT_MAX
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic sleep_pin,
  input wire logic serial_in_line_valid,
  input wire logic rf_carrier,
  input wire logic rf_byte_valid,
  input wire logic [7:0] rf_byte,
  input wire logic rf_pkt_end,
  input wire logic rf_error,
  input wire logic tx_done,
  input wire logic ser_out_ready,
  output logic cts_n,
  output logic activity_indicator,
  output logic rx_enable,
  output logic tx_req,
  output logic long_header,
  output logic ser_out_valid,
  output logic [7:0] ser_out_data
);
  localparam int DEPTH = PKT_MAX + SLRM_CRC_BYTES;
  localparam int LW = $clog2(DEPTH + 1);

  typedef struct packed {
    slrm_mode_t mode;
    logic [2:0] sm;
    logic [15:0] st_ms;
    logic [15:0] lh_ms;
    logic [15:0] ht_ms;
    logic [12:0] tmr_ms;
    logic [15:0] inact_ms;
    logic [15:0] hdr_ms;
    logic hdr_due;
    logic [15:0] lh_cnt;
    logic pend;
    logic chk;
    logic [LW-1:0] len;
    logic [DEPTH-1:0][7:0] pbuf;
    logic fwd;
    logic [LW-1:0] fwd_idx;
    logic [LW-1:0] fwd_len;
    logic [7:0] drops;
    logic cts_n;
    logic act;
    logic rx_en;
    logic tx_req;
    logic long_hdr;
    logic out_valid;
    logic [7:0] out_data;
    logic [15:0] rdata;
  } slrm_ctrl_t;

  slrm_ctrl_t s_ff;
  slrm_ctrl_t nxt_s;
  logic tick;
  logic [15:0] crc;
  logic crc_clr;
  logic crc_en;
  logic busy;
  logic auto_sleep;
  logic [12:0] cyc_ms;
  logic [15:0] stat;

  slrm_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .core_clk(core_clk),
    .rstn(rstn),
    .tick(tick)
  );

  // Cleared after each check and whenever not receiving
  assign crc_clr = s_ff.chk || (s_ff.mode != SLRM_RX);
  assign crc_en = (s_ff.mode == SLRM_RX) && rf_byte_valid;

  slrm_crc16 u_crc (
    .core_clk(core_clk),
    .rstn(rstn),
    .clr(crc_clr),
    .en(crc_en),
    .data(rf_byte),
    .crc(crc)
  );

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_s = s_ff;
    nxt_s.chk = 1'b0;
    busy = (s_ff.mode == SLRM_RX) || (s_ff.mode == SLRM_TX) ||
           serial_in_line_valid;
    auto_sleep = ((s_ff.sm == SLRM_SM_SER) || (s_ff.sm >= SLRM_SM_CYC_MIN))
                 && (s_ff.inact_ms >= s_ff.st_ms);
    cyc_ms = 13'(SLRM_CYC_BASE_MS) << (s_ff.sm - SLRM_SM_CYC_MIN);
    stat = '0;
    stat[SLRM_STAT_MODE +: 3] = s_ff.mode;
    stat[SLRM_STAT_PEND] = s_ff.pend;
    stat[SLRM_STAT_CTS_N] = s_ff.cts_n;
    stat[SLRM_STAT_ACT] = s_ff.act;
    stat[SLRM_STAT_LHDR] = s_ff.long_hdr;
    stat[SLRM_STAT_FWD] = s_ff.fwd;

    // Register port
    if (reg_wr) begin
      case (reg_addr)
        SLRM_REG_SM: nxt_s.sm = reg_wdata[2:0];
        SLRM_REG_ST: nxt_s.st_ms = reg_wdata;
        SLRM_REG_LH: nxt_s.lh_ms = reg_wdata;
        SLRM_REG_HT: nxt_s.ht_ms = reg_wdata;
        default: ;
      endcase
    end
    nxt_s.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        SLRM_REG_SM: nxt_s.rdata = {13'h0000, s_ff.sm};
        SLRM_REG_ST: nxt_s.rdata = s_ff.st_ms;
        SLRM_REG_LH: nxt_s.rdata = s_ff.lh_ms;
        SLRM_REG_HT: nxt_s.rdata = s_ff.ht_ms;
        SLRM_REG_STAT: nxt_s.rdata = stat;
        SLRM_REG_DROP: nxt_s.rdata = {8'h00, s_ff.drops};
        default: nxt_s.rdata = '0;
      endcase
    end

    // Millisecond counters, saturating
    if (tick && (s_ff.tmr_ms != 13'h1fff)) begin
      nxt_s.tmr_ms = s_ff.tmr_ms + 13'h0001;
    end
    // Sample the idle time before the first character clears it
    if (serial_in_line_valid && !s_ff.pend && (s_ff.mode != SLRM_TX)) begin
      nxt_s.hdr_due = (s_ff.hdr_ms >= s_ff.ht_ms);
    end
    if (busy || rf_carrier) begin
      nxt_s.inact_ms = '0;
      nxt_s.hdr_ms = '0;
    end else if (tick) begin
      if (s_ff.inact_ms != 16'hffff) begin
        nxt_s.inact_ms = s_ff.inact_ms + 16'h0001;
      end
      if (s_ff.hdr_ms != 16'hffff) begin
        nxt_s.hdr_ms = s_ff.hdr_ms + 16'h0001;
      end
    end
    if (serial_in_line_valid && (s_ff.mode != SLRM_TX)) begin
      nxt_s.pend = 1'b1;
    end

    // Packet verdict one cycle after the last byte
    if (s_ff.chk) begin
      if ((crc == 16'h0000) && (s_ff.len > LW'(SLRM_CRC_BYTES))) begin
        nxt_s.fwd = 1'b1;
        nxt_s.fwd_idx = '0;
        nxt_s.fwd_len = s_ff.len - LW'(SLRM_CRC_BYTES);
      end else begin
        nxt_s.drops = s_ff.drops + 8'h01;
      end
      nxt_s.len = '0;
    end

    case (s_ff.mode)
      SLRM_IDLE: begin
        if (rf_carrier) begin
          nxt_s.mode = SLRM_RX;
          nxt_s.len = '0;
        end else if (s_ff.pend) begin
          nxt_s.mode = SLRM_TX;
        end else if ((s_ff.sm == SLRM_SM_PIN) && sleep_pin) begin
          nxt_s.mode = SLRM_SLEEP;
        end else if (auto_sleep) begin
          nxt_s.mode = SLRM_SLEEP;
        end
      end
      SLRM_RX: begin
        if (rf_byte_valid) begin
          if (nxt_s.len == LW'(DEPTH)) begin
            nxt_s.mode = SLRM_IDLE;
            nxt_s.drops = s_ff.drops + 8'h01;
          end else begin
            nxt_s.pbuf[nxt_s.len] = rf_byte;
            nxt_s.len = nxt_s.len + LW'(1);
            nxt_s.chk = rf_pkt_end;
          end
        end
        if (rf_error) begin
          nxt_s.mode = SLRM_IDLE;
          nxt_s.chk = 1'b0;
          nxt_s.drops = s_ff.drops + 8'h01;
        end else if (!rf_carrier && !rf_byte_valid) begin
          nxt_s.mode = SLRM_IDLE;
        end
      end
      SLRM_TX: begin
        if (tx_done) begin
          nxt_s.mode = SLRM_IDLE;
        end
      end
      SLRM_SLEEP: begin
        if (s_ff.sm == SLRM_SM_OFF) begin
          nxt_s.mode = SLRM_IDLE;
        end else if (s_ff.sm == SLRM_SM_PIN) begin
          if (!sleep_pin) begin
            nxt_s.mode = SLRM_PWAKE;
          end
        end else if (s_ff.sm == SLRM_SM_SER) begin
          if (serial_in_line_valid) begin
            nxt_s.mode = SLRM_IDLE;
          end
        end else if (tick && (s_ff.tmr_ms == cyc_ms - 13'h0001)) begin
          nxt_s.mode = SLRM_LISTEN;
        end
      end
      SLRM_PWAKE: begin
        if (s_ff.sm != SLRM_SM_PIN) begin
          nxt_s.mode = SLRM_IDLE;
        end else if (sleep_pin) begin
          nxt_s.mode = SLRM_SLEEP;
        end else if (tick &&
                     (s_ff.tmr_ms == 13'(SLRM_PWAKE_MS - 1))) begin
          nxt_s.mode = SLRM_IDLE;
        end
      end
      SLRM_LISTEN: begin
        if (rf_carrier) begin
          nxt_s.mode = SLRM_RX;
          nxt_s.len = '0;
        end else if (s_ff.pend) begin
          nxt_s.mode = SLRM_TX;
        end else if (s_ff.sm < SLRM_SM_CYC_MIN) begin
          nxt_s.mode = SLRM_IDLE;
        end else if (tick &&
                     (s_ff.tmr_ms == 13'(SLRM_LISTEN_MS - 1))) begin
          nxt_s.mode = SLRM_SLEEP;
        end
      end
      default: nxt_s.mode = SLRM_IDLE;
    endcase

    if (nxt_s.mode != s_ff.mode) begin
      nxt_s.tmr_ms = '0;
      nxt_s.inact_ms = '0;
    end

    // Long header decided once, at entry to transmit
    if ((nxt_s.mode == SLRM_TX) && (s_ff.mode != SLRM_TX)) begin
      nxt_s.pend = 1'b0;
      nxt_s.lh_cnt = '0;
      nxt_s.long_hdr = (nxt_s.lh_ms != 16'h0000) &&
                       s_ff.hdr_due;
      nxt_s.hdr_due = 1'b0;
    end else if ((nxt_s.mode != SLRM_TX) || (nxt_s.lh_ms == 16'h0000)) begin
      nxt_s.long_hdr = 1'b0;
    end else if (s_ff.long_hdr && tick) begin
      nxt_s.lh_cnt = s_ff.lh_cnt + 16'h0001;
      if (s_ff.lh_cnt == s_ff.lh_ms - 16'h0001) begin
        nxt_s.long_hdr = 1'b0;
      end
    end

    // Forwarding drains faster than air fills; no second packet store
    if (s_ff.out_valid && !ser_out_ready) begin
      nxt_s.out_valid = 1'b1;
    end else if (s_ff.fwd) begin
      nxt_s.out_valid = 1'b1;
      nxt_s.out_data = s_ff.pbuf[s_ff.fwd_idx];
      nxt_s.fwd_idx = s_ff.fwd_idx + LW'(1);
      if (s_ff.fwd_idx + LW'(1) == s_ff.fwd_len) begin
        nxt_s.fwd = s_ff.chk ? nxt_s.fwd : 1'b0;
      end
    end else begin
      nxt_s.out_valid = 1'b0;
    end

    // Pin levels follow the next mode
    nxt_s.cts_n = ((nxt_s.mode == SLRM_SLEEP) && (nxt_s.sm != SLRM_SM_SER))
                  || (nxt_s.mode == SLRM_PWAKE);
    nxt_s.act = (nxt_s.mode != SLRM_SLEEP) &&
                (nxt_s.mode != SLRM_PWAKE);
    nxt_s.rx_en = (nxt_s.mode == SLRM_IDLE) || (nxt_s.mode == SLRM_RX) ||
                  (nxt_s.mode == SLRM_LISTEN);
    nxt_s.tx_req = (nxt_s.mode == SLRM_TX);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_ff <= '0;
      s_ff.sm <= SLRM_SM_RST;
      s_ff.st_ms <= SLRM_ST_RST;
      s_ff.lh_ms <= SLRM_LH_RST;
      s_ff.ht_ms <= SLRM_HT_RST;
      s_ff.act <= 1'b1;
      s_ff.rx_en <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign reg_rdata = s_ff.rdata;
  assign cts_n = s_ff.cts_n;
  assign activity_indicator = s_ff.act;
  assign rx_enable = s_ff.rx_en;
  assign tx_req = s_ff.tx_req;
  assign long_header = s_ff.long_hdr;
  assign ser_out_valid = s_ff.out_valid;
  assign ser_out_data = s_ff.out_data;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_pwake_exit;
    (s_ff.mode == SLRM_PWAKE) ##1 (s_ff.mode == SLRM_IDLE);
  endsequence
  sequence s_listen_end;
    (s_ff.mode == SLRM_LISTEN) ##1 (s_ff.mode == SLRM_SLEEP);
  endsequence
  sequence s_cyc_wake;
    (s_ff.mode == SLRM_SLEEP && s_ff.sm >= SLRM_SM_CYC_MIN)
      ##1 (s_ff.mode == SLRM_LISTEN);
  endsequence
  sequence s_auto_enter;
    (s_ff.mode == SLRM_IDLE && s_ff.sm != SLRM_SM_PIN)
      ##1 (s_ff.mode == SLRM_SLEEP);
  endsequence

  a_idle_to_rx: assert property (
    (s_ff.mode == SLRM_IDLE && rf_carrier) |=> (s_ff.mode == SLRM_RX))
    else $error("idle did not enter receive on carrier");
  a_bad_crc_drop: assert property (
    (s_ff.chk && crc != 16'h0000 && !s_ff.fwd) |=> !s_ff.fwd ##1 !ser_out_valid)
    else $error("packet with bad check was forwarded");
  a_rx_hold_serial: assert property (
    (s_ff.mode == SLRM_RX && serial_in_line_valid) |=> s_ff.pend && !tx_req)
    else $error("serial byte in receive not held");
  a_sleep_quiet: assert property (
    (s_ff.mode == SLRM_SLEEP) |-> !rx_enable && !tx_req)
    else $error("radio active while asleep");
  a_auto_sleep_time: assert property (
    s_auto_enter |-> $past(s_ff.inact_ms) >= $past(s_ff.st_ms))
    else $error("sleep entered before inactivity period");
  a_pwake_time: assert property (
    s_pwake_exit |-> $past(s_ff.tmr_ms) == 13'(SLRM_PWAKE_MS - 1)
                     || $past(s_ff.sm) != SLRM_SM_PIN)
    else $error("pin wake did not take its full time");
  a_pin_ignored: assert property (
    (s_ff.sm != SLRM_SM_PIN) ##1 (s_ff.sm != SLRM_SM_PIN)
      |-> s_ff.mode != SLRM_PWAKE)
    else $error("sleep pin acted outside pin mode");
  a_pin_sleep_pins: assert property (
    (s_ff.mode == SLRM_SLEEP && s_ff.sm == SLRM_SM_PIN)
      |-> cts_n && !activity_indicator)
    else $error("pin sleep pin levels wrong");
  a_ser_wake: assert property (
    (s_ff.mode == SLRM_SLEEP && s_ff.sm == SLRM_SM_SER && serial_in_line_valid)
      |=> s_ff.mode == SLRM_IDLE)
    else $error("serial character did not wake");
  a_cyc_period: assert property (
    s_cyc_wake |-> $past(s_ff.tmr_ms) == $past(cyc_ms) - 13'h0001)
    else $error("cyclic sleep period wrong");
  a_listen_time: assert property (
    s_listen_end |-> $past(s_ff.tmr_ms) == 13'(SLRM_LISTEN_MS - 1))
    else $error("search window not 100 ms");
  a_cyc_pins: assert property (
    (s_ff.mode == SLRM_LISTEN) |-> !cts_n && activity_indicator)
    else $error("cyclic wake pin levels wrong");
  a_never_sleep: assert property (
    (s_ff.sm == SLRM_SM_OFF) ##1 (s_ff.sm == SLRM_SM_OFF)
      |-> s_ff.mode != SLRM_SLEEP)
    else $error("slept with sleep disabled");
  a_lh_off: assert property (
    (s_ff.lh_ms == 16'h0000) |-> !long_header)
    else $error("long header sent while disabled");
endmodule
`default_nettype wire

/* tb/slrm_host.sv */
// Host processor model on the serial, flow-control and sleep pins
`default_nettype none
module slrm_host (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cts_n,
  input wire logic ser_out_valid,
  input wire logic [7:0] ser_out_data,
  input wire logic sleep_req,
  input wire logic send_req,
  input wire logic stall,
  output logic sleep_pin,
  output logic serial_in_line_valid,
  output logic ser_out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  ////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sleep_pin <= 1'b0;
      serial_in_line_valid <= 1'b0;
      ser_out_ready <= 1'b1;
    end else begin
      sleep_pin <= sleep_req;
      ser_out_ready <= !stall;
      // One character per request, never while the permit is high
      serial_in_line_valid <= send_req && !cts_n &&
                              !serial_in_line_valid;
      if (ser_out_valid && ser_out_ready) begin
        got.push_back(ser_out_data);
      end
    end
  end
endmodule
`default_nettype wire

/* tb/slrm_ctrl_tb_top.sv */
// Self-checking bench for the sleep and receive mode controller
`default_nettype none
module slrm_ctrl_tb_top import slrm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Short tick keeps the 8 s cyclic period affordable
  localparam int TK = 4;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rf_carrier = 1'b0;
  logic rf_byte_valid = 1'b0;
  logic [7:0] rf_byte = 8'h00;
  logic rf_pkt_end = 1'b0;
  logic rf_error = 1'b0;
  logic tx_done = 1'b0;
  logic sleep_req = 1'b0;
  logic send_req = 1'b0;
  logic stall = 1'b0;
  logic [15:0] reg_rdata;
  logic sleep_pin, serial_in_line_valid, ser_out_ready;
  logic cts_n, activity_indicator, rx_enable, tx_req, long_header;
  logic ser_out_valid;
  logic [7:0] ser_out_data;
  logic [15:0] v;
  logic [7:0] pl[$];
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  always #10 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////
  slrm_ctrl #(.TICK_CYCLES(TK)) uut (.core_clk(core_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_pin(sleep_pin),
    .serial_in_line_valid(serial_in_line_valid), .rf_carrier(rf_carrier),
    .rf_byte_valid(rf_byte_valid), .rf_byte(rf_byte),
    .rf_pkt_end(rf_pkt_end), .rf_error(rf_error), .tx_done(tx_done),
    .ser_out_ready(ser_out_ready), .cts_n(cts_n),
    .activity_indicator(activity_indicator), .rx_enable(rx_enable),
    .tx_req(tx_req), .long_header(long_header),
    .ser_out_valid(ser_out_valid), .ser_out_data(ser_out_data));
  slrm_host host (.core_clk(core_clk), .rstn(rstn), .cts_n(cts_n),
    .ser_out_valid(ser_out_valid), .ser_out_data(ser_out_data),
    .sleep_req(sleep_req), .send_req(send_req), .stall(stall),
    .sleep_pin(sleep_pin), .serial_in_line_valid(serial_in_line_valid),
    .ser_out_ready(ser_out_ready));
  ////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task check(input string nm, input logic [15:0] seen,
             input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task rng(input string nm, input int lo, input int hi);
    check(nm, 16'(n >= lo && n <= hi), 16'h0001);
  endtask
  task tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
    tick(1);
  endtask
  task chk_mode(input logic [2:0] m);
    rd(SLRM_REG_STAT, v);
    check("mode", 16'(v[2:0]), 16'(m));
  endtask
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] d);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0};
      if (fb) c = c ^ SLRM_CRC_POLY;
    end
    return c;
  endfunction
  // Gap cycle after every byte; released byte lane shows a moving value
  task send(input logic [7:0] b, input logic last);
    rf_byte_valid <= 1'b1;
    rf_byte <= b;
    rf_pkt_end <= last;
    tick(1);
    rf_byte_valid <= 1'b0;
    rf_pkt_end <= 1'b0;
    rf_byte <= ~b;
    tick(1);
  endtask
  task rx_pkt(input logic bad);
    logic [15:0] c;
    c = SLRM_CRC_INIT;
    foreach (pl[i]) c = crc_step(c, pl[i]);
    c[0] = c[0] ^ bad;
    host.got.delete();
    rf_carrier <= 1'b1;
    tick(2);
    foreach (pl[i]) send(pl[i], 1'b0);
    send(c[15:8], 1'b0);
    send(c[7:0], 1'b1);
    tick(2);
  endtask
  task chk_fwd;
    check("fwd_n", 16'(host.got.size()), 16'(pl.size()));
    foreach (pl[i]) check("fwd_byte", 16'(host.got[i]), 16'(pl[i]));
  endtask
  task send_char;
    send_req <= 1'b1;
    n = 0;
    while (serial_in_line_valid !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    send_req <= 1'b0;
    if (n >= 1000) begin
      n_mismatch++;
    end
  endtask
  task end_tx(input logic lh);
    n = 0;
    while (tx_req !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check("tx_req", 16'(tx_req), 16'h0001);
    check("long_hdr", 16'(long_header), 16'(lh));
    tick(1);
    tx_done <= 1'b1;
    tick(1);
    tx_done <= 1'b0;
    tick(2);
    check("tx_end", 16'(tx_req), 16'h0000);
  endtask
  task wait_act(input logic l);
    n = 0;
    while (activity_indicator !== l && n < 40000) begin
      tick(1);
      n++;
    end
    if (n >= 40000) begin
      n_mismatch++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(8);
    rstn <= 1'b1;
    tick(1);
    check("cts_n", 16'(cts_n), 16'h0000);
    check("act", 16'(activity_indicator), 16'h0001);
    check("rx_en", 16'(rx_enable), 16'h0001);
    rd(SLRM_REG_SM, v);
    check("sm", v, 16'h0000);
    rd(SLRM_REG_LH, v);
    check("lh", v, 16'h0000);
    rd(SLRM_REG_HT, v);
    check("ht", v, SLRM_HT_RST);
    wr(4'h6, 16'hffff);
    rd(4'h6, v);
    check("unmapped", v, 16'h0000);
    rd(SLRM_REG_ST, v);
    check("st", v, SLRM_ST_RST);
    // Good packet while the host stalls the output
    pl = '{8'ha1, 8'hb2, 8'hc3};
    stall <= 1'b1;
    rx_pkt(1'b0);
    check("fwd_hold", 16'(ser_out_valid), 16'h0001);
    chk_mode(SLRM_RX);
    stall <= 1'b0;
    tick(20);
    chk_fwd();
    rx_pkt(1'b1);
    tick(20);
    check("bad_fwd", 16'(host.got.size()), 16'h0000);
    // Character held back until receive ends
    send_char();
    tick(5);
    check("tx_wait", 16'(tx_req), 16'h0000);
    rf_carrier <= 1'b0;
    end_tx(1'b0);
    rf_carrier <= 1'b1;
    tick(2);
    send(8'h55, 1'b0);
    rf_error <= 1'b1;
    tick(1);
    rf_error <= 1'b0;
    rf_carrier <= 1'b0;
    tick(3);
    rd(SLRM_REG_DROP, v);
    check("drops", v, 16'h0002);
    chk_mode(SLRM_IDLE);
    wr(SLRM_REG_LH, 16'h0005);
    wr(SLRM_REG_HT, 16'h0003);
    tick(6 * TK);
    send_char();
    end_tx(1'b1);
    send_char();
    end_tx(1'b0);
    // Pin sleep
    sleep_req <= 1'b1;
    tick(10);
    check("pin_ign", 16'(activity_indicator), 16'h0001);
    wr(SLRM_REG_SM, 16'(SLRM_SM_PIN));
    tick(4);
    check("pin_cts", 16'(cts_n), 16'h0001);
    check("pin_act", 16'(activity_indicator), 16'h0000);
    check("pin_rx", 16'(rx_enable), 16'h0000);
    rf_carrier <= 1'b1;
    tick(4);
    chk_mode(SLRM_SLEEP);
    rf_carrier <= 1'b0;
    sleep_req <= 1'b0;
    wait_act(1'b1);
    rng("pin_wake", 84 * TK, 86 * TK + 4);
    check("wake_cts", 16'(cts_n), 16'h0000);
    // Serial port sleep
    wr(SLRM_REG_ST, 16'h0005);
    wr(SLRM_REG_LH, 16'h0000);
    wr(SLRM_REG_SM, 16'(SLRM_SM_SER));
    send_char();
    end_tx(1'b0);
    wait_act(1'b0);
    rng("ser_inact", 4 * TK, 6 * TK + 6);
    check("ser_cts", 16'(cts_n), 16'h0000);
    check("ser_rx", 16'(rx_enable), 16'h0000);
    send_char();
    tick(2);
    check("ser_wake", 16'(activity_indicator), 16'h0001);
    end_tx(1'b0);
    // Cyclic sleep, every period code
    for (int s = 3; s <= 7; s++) begin
      wr(SLRM_REG_SM, 16'(s));
      wait_act(1'b0);
      check("cyc_cts", 16'(cts_n), 16'h0001);
      // Peer long header outlasts the whole sleep period
      if (s == 3) begin
        rf_carrier <= 1'b1;
      end
      wait_act(1'b1);
      rng("cyc_sleep", (500 << (s - 3)) * TK - 2 * TK,
          (500 << (s - 3)) * TK + 2 * TK + 4);
      check("awake_cts", 16'(cts_n), 16'h0000);
      if (s == 3) begin
        tick(2);
        chk_mode(SLRM_RX);
        rf_carrier <= 1'b0;
        wait_act(1'b0);
      end else if (s == 4) begin
        pl = '{8'h3c};
        rx_pkt(1'b0);
        rf_carrier <= 1'b0;
        tick(20);
        chk_fwd();
        wait_act(1'b0);
      end else if (s == 6) begin
        send_char();
        end_tx(1'b0);
        wait_act(1'b0);
      end else begin
        wait_act(1'b0);
        rng("listen", 99 * TK, 101 * TK + 4);
      end
      wr(SLRM_REG_SM, 16'(SLRM_SM_OFF));
      tick(2);
      check("sm_off", 16'(activity_indicator), 16'h0001);
    end
    stop_test();
  end
endmodule
`default_nettype wire
